// ### include/timer_pulse_defines.svh
// constants of the one-pulse / pwm timer: register offsets, field positions, reset values
// assumes a byte-wide register port with one-cycle strobes from the cpu side
`ifndef TIMER_PULSE_DEFINES_SVH
`define TIMER_PULSE_DEFINES_SVH

`define TP_ADDR_W        4
`define TP_CTRL1         4'h0
`define TP_CTRL2         4'h1
`define TP_STATUS        4'h2
`define TP_CAP1_HIGH     4'h3
`define TP_CAP1_LOW      4'h4
`define TP_CAP2_HIGH     4'h5
`define TP_CAP2_LOW      4'h6
`define TP_CMP1_HIGH     4'h7
`define TP_CMP1_LOW      4'h8
`define TP_CMP2_HIGH     4'h9
`define TP_CMP2_LOW      4'ha
`define TP_CNT_HIGH      4'hb
`define TP_CNT_LOW       4'hc

`define TP_CR1_CAPTURE_INTERRUPT_ENABLE      7
`define TP_CR1_OCIE      6
`define TP_CR1_TOIE      5
`define TP_CR1_LVL2      2
`define TP_CR1_EDGE1     1
`define TP_CR1_LVL1      0
`define TP_CR2_PIN1      7
`define TP_CR2_PIN2      6
`define TP_CR2_OPM       5
`define TP_CR2_PWM       4
`define TP_CR2_CC_HI     3
`define TP_CR2_CC_LO     2
`define TP_CR2_EDGE2     1
`define TP_CR2_EXEDGE    0

`define TP_SR_CAPTURE_FLAG_FIRST       7
`define TP_SR_COMPARE_FLAG_FIRST       6
`define TP_SR_TOF        5
`define TP_SR_CAPTURE_FLAG_SECOND       4
`define TP_SR_COMPARE_FLAG_SECOND       3

`define TP_CNT_RELOAD    16'hfffc
`define TP_CNT_MAX       16'hffff
`define TP_TRIG_CAPTURE  16'hfffd
`define TP_CMP_RESET     16'h8000
`define TP_CTRL_RESET    8'h00

`define TP_TICK_DIV4     2'b00
`define TP_TICK_DIV2     2'b01
`define TP_TICK_DIV8     2'b10
`define TP_TICK_EXT      2'b11

`endif

// ### include/timer_pulse_pkg.sv
// types of the one-pulse / pwm timer
// assumes nothing beyond the constants header
package timer_pulse_pkg;
  typedef enum logic [1:0]
  {
    MODE_NORMAL    = 2'b00,
    MODE_ONE_PULSE = 2'b01,
    MODE_PWM       = 2'b11
  } timer_mode_t;
endpackage

// ### logic/timer_one_pulse_and_pwm.sv
// 16-bit timer with capture, compare, one-pulse and pwm modes, halt and wait behaviour
// assumes pins arrive asynchronously; halt, wait and mask come from cpu logic on mclk
`timescale 1ns/10ps
`include "timer_pulse_defines.svh"

module timer_one_pulse_and_pwm
  import timer_pulse_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  reset,
  input  wire logic [`TP_ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [7:0]            reg_rdata,
  input  wire logic                  capture_input_first,
  input  wire logic                  capture_input_second,
  input  wire logic                  ext_tick_pin,
  input  wire logic                  halt_mode,
  input  wire logic                  wait_mode,
  input  wire logic                  cpu_int_mask,
  output logic                       compare_output_first,
  output logic                       compare_drive_first_n,
  output logic                       compare_output_second,
  output logic                       compare_drive_second_n,
  output logic                       timer_irq,
  output logic                       wait_wake
);

  logic [7:0]  ctrl1_q;
  logic [7:0]  ctrl2_q;
  logic [15:0] cnt_q;
  logic [15:0] cap1_q;
  logic [15:0] cap2_q;
  logic [15:0] cmp1_q;
  logic [15:0] cmp2_q;
  logic [1:0]  cmp_inh_q;
  logic [1:0]  cap_inh_q;
  logic [1:0]  cap_arm_q;
  logic [7:0]  flags_q;
  logic [7:0]  flags_d;
  logic [7:0]  seen_q;
  logic [7:0]  clr_acc;
  logic [2:0]  pre_q;
  logic [1:0]  s1_q;
  logic [1:0]  s2_q;
  logic [1:0]  sx_q;
  logic        p1_q;
  logic        p2_q;
  logic        px_q;
  logic        halt_prev_q;
  logic        out1_q;
  logic        out2_q;
  logic [7:0]  rdata_q;
  timer_mode_t mode;
  logic [1:0]  tick_sel;
  logic        edge1;
  logic        edge2;
  logic        ext_edge;
  logic        tick_raw;
  logic        tick;
  logic        halt_exit;
  logic        trig;
  logic        cap1_evt;
  logic        cap2_evt;
  logic        match1;
  logic        match2;
  logic        pwm_wrap;
  logic        overflow;
  logic        wr_at;
  logic        rd_at;

  assign tick_sel = ctrl2_q[`TP_CR2_CC_HI:`TP_CR2_CC_LO];

  // pwm wins over one-pulse when both are selected
  always_comb
  begin
    if (ctrl2_q[`TP_CR2_PWM])
      mode = MODE_PWM;
    else if (ctrl2_q[`TP_CR2_OPM])
      mode = MODE_ONE_PULSE;
    else
      mode = MODE_NORMAL;
  end

  // pin synchronisers: stage 0 feeds only stage 1, the third flop is for edge detection
  // left running through reset so they hold the idle pin level and no false edge follows release
  always_ff @(posedge mclk)
  begin
    s1_q <= {s1_q[0], capture_input_first};
    s2_q <= {s2_q[0], capture_input_second};
    sx_q <= {sx_q[0], ext_tick_pin};
    p1_q <= s1_q[1];
    p2_q <= s2_q[1];
    px_q <= sx_q[1];
  end

  assign edge1 = ctrl1_q[`TP_CR1_EDGE1] ? (s1_q[1] & ~p1_q) : (~s1_q[1] & p1_q);
  assign edge2 = ctrl2_q[`TP_CR2_EDGE2] ? (s2_q[1] & ~p2_q) : (~s2_q[1] & p2_q);
  assign ext_edge = ctrl2_q[`TP_CR2_EXEDGE] ? (sx_q[1] & ~px_q) : (~sx_q[1] & px_q);

  // free prescaler; the tick falls where the low bits are all ones, so spacing is exact
  always_ff @(posedge mclk)
  begin
    if (reset)
      pre_q <= 3'h0;
    else if (!halt_mode)
      pre_q <= pre_q + 3'h1;
  end

  always_comb
  begin
    unique case (tick_sel)
      `TP_TICK_DIV4: tick_raw = &pre_q[1:0];
      `TP_TICK_DIV2: tick_raw = pre_q[0];
      `TP_TICK_DIV8: tick_raw = &pre_q;
      `TP_TICK_EXT:  tick_raw = ext_edge;
    endcase
  end

  // wait changes nothing, halt stops the tick
  assign tick      = tick_raw & ~halt_mode;
  assign halt_exit = halt_prev_q & ~halt_mode;

  assign trig     = (mode == MODE_ONE_PULSE) & edge1 & ~halt_mode;
  assign cap1_evt = (mode == MODE_NORMAL) & edge1 & ~halt_mode & ~cap_inh_q[0];
  assign cap2_evt = edge2 & ~halt_mode & ~cap_inh_q[1];
  assign match1   = tick & (cnt_q == cmp1_q) & ~cmp_inh_q[0];
  assign match2   = tick & (cnt_q == cmp2_q) & ~cmp_inh_q[1];
  assign pwm_wrap = (mode == MODE_PWM) & match2;
  assign overflow = tick & (cnt_q == `TP_CNT_MAX) & ~pwm_wrap;

  assign wr_at = reg_wr;
  assign rd_at = reg_rd;

  always_ff @(posedge mclk)
  begin
    if (reset)
      halt_prev_q <= 1'b0;
    else
      halt_prev_q <= halt_mode;
  end

  // reloading at the second match gives a period of value plus five ticks
  always_ff @(posedge mclk)
  begin
    if (reset)
      cnt_q <= `TP_CNT_RELOAD;
    else if (trig || pwm_wrap)
      cnt_q <= `TP_CNT_RELOAD;
    else if (tick)
      cnt_q <= cnt_q + 16'h0001;
  end

  // second-input edges, and first-input edges in normal mode, during halt are remembered and turned into captures at wake
  always_ff @(posedge mclk)
  begin
    if (reset)
      cap_arm_q <= 2'h0;
    else if (halt_mode)
    begin
      if (edge1 && mode == MODE_NORMAL)
        cap_arm_q[0] <= 1'b1;
      if (edge2)
        cap_arm_q[1] <= 1'b1;
    end
    else if (halt_exit)
      cap_arm_q <= 2'h0;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      cap1_q <= 16'h0000;
      cap2_q <= 16'h0000;
    end
    else
    begin
      if (trig)
        cap1_q <= `TP_TRIG_CAPTURE;
      else if (cap1_evt || (halt_exit && cap_arm_q[0]))
        cap1_q <= cnt_q;
      if (cap2_evt || (halt_exit && cap_arm_q[1]))
        cap2_q <= cnt_q;
    end
  end

  // reading a capture high byte blocks edge captures into it until its low byte is read; a trigger (first capture only) or a halt wake capture still loads it
  always_ff @(posedge mclk)
  begin
    if (reset)
      cap_inh_q <= 2'h0;
    else if (rd_at)
    begin
      if (reg_addr == `TP_CAP1_HIGH)
        cap_inh_q[0] <= 1'b1;
      else if (reg_addr == `TP_CAP1_LOW)
        cap_inh_q[0] <= 1'b0;
      else if (reg_addr == `TP_CAP2_HIGH)
        cap_inh_q[1] <= 1'b1;
      else if (reg_addr == `TP_CAP2_LOW)
        cap_inh_q[1] <= 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ctrl1_q <= `TP_CTRL_RESET;
      ctrl2_q <= `TP_CTRL_RESET;
    end
    else if (wr_at && reg_addr == `TP_CTRL1)
      ctrl1_q <= reg_wdata;
    else if (wr_at && reg_addr == `TP_CTRL2)
      ctrl2_q <= reg_wdata;
  end

  // the compare pair is split so a half-written value never matches
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      cmp1_q    <= `TP_CMP_RESET;
      cmp2_q    <= `TP_CMP_RESET;
      cmp_inh_q <= 2'h0;
    end
    else if (wr_at)
    begin
      unique case (reg_addr)
        `TP_CMP1_HIGH:
        begin
          cmp1_q[15:8] <= reg_wdata;
          cmp_inh_q[0] <= 1'b1;
        end
        `TP_CMP1_LOW:
        begin
          cmp1_q[7:0]  <= reg_wdata;
          cmp_inh_q[0] <= 1'b0;
        end
        `TP_CMP2_HIGH:
        begin
          cmp2_q[15:8] <= reg_wdata;
          cmp_inh_q[1] <= 1'b1;
        end
        `TP_CMP2_LOW:
        begin
          cmp2_q[7:0]  <= reg_wdata;
          cmp_inh_q[1] <= 1'b0;
        end
        default:
        begin
          cmp_inh_q <= cmp_inh_q;
        end
      endcase
    end
  end

  // low-byte accesses that complete a flag clear
  always_comb
  begin
    clr_acc = 8'h00;
    clr_acc[`TP_SR_CAPTURE_FLAG_FIRST] = (rd_at || wr_at) && reg_addr == `TP_CAP1_LOW;
    clr_acc[`TP_SR_CAPTURE_FLAG_SECOND] = (rd_at || wr_at) && reg_addr == `TP_CAP2_LOW;
    clr_acc[`TP_SR_COMPARE_FLAG_FIRST] = (rd_at || wr_at) && reg_addr == `TP_CMP1_LOW;
    clr_acc[`TP_SR_COMPARE_FLAG_SECOND] = (rd_at || wr_at) && reg_addr == `TP_CMP2_LOW;
    clr_acc[`TP_SR_TOF]  = (rd_at || wr_at) && reg_addr == `TP_CNT_LOW;
  end

  // a new event in the clearing cycle keeps the flag set
  always_comb
  begin
    flags_d = flags_q & ~(seen_q & clr_acc);
    if (trig || cap1_evt || pwm_wrap || (halt_exit && cap_arm_q[0]))
      flags_d[`TP_SR_CAPTURE_FLAG_FIRST] = 1'b1;
    if (cap2_evt || (halt_exit && cap_arm_q[1]))
      flags_d[`TP_SR_CAPTURE_FLAG_SECOND] = 1'b1;
    if (mode == MODE_NORMAL && match1)
      flags_d[`TP_SR_COMPARE_FLAG_FIRST] = 1'b1;
    if (mode != MODE_PWM && match2)
      flags_d[`TP_SR_COMPARE_FLAG_SECOND] = 1'b1;
    if (overflow)
      flags_d[`TP_SR_TOF] = 1'b1;
    flags_d[2:0] = 3'h0;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      flags_q <= 8'h00;
    else
      flags_q <= flags_d;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      seen_q <= 8'h00;
    else if (rd_at && reg_addr == `TP_STATUS)
      seen_q <= flags_q;
    else
      seen_q <= seen_q & ~clr_acc;
  end

  // the first output keeps its level between events, so a finished pulse holds the LVL1 level
  always_ff @(posedge mclk)
  begin
    if (reset)
      out1_q <= 1'b0;
    else if (trig || pwm_wrap)
      out1_q <= ctrl1_q[`TP_CR1_LVL2];
    else if (match1)
      out1_q <= ctrl1_q[`TP_CR1_LVL1];
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      out2_q <= 1'b0;
    else if (mode == MODE_NORMAL && match2)
      out2_q <= ctrl1_q[`TP_CR1_LVL2];
  end

  assign compare_output_first   = out1_q;
  assign compare_output_second  = out2_q;
  assign compare_drive_first_n  = ~ctrl2_q[`TP_CR2_PIN1];
  assign compare_drive_second_n = ~ctrl2_q[`TP_CR2_PIN2];

  assign timer_irq = ~cpu_int_mask &
                     ((ctrl1_q[`TP_CR1_CAPTURE_INTERRUPT_ENABLE] & (flags_q[`TP_SR_CAPTURE_FLAG_FIRST] | flags_q[`TP_SR_CAPTURE_FLAG_SECOND])) |
                      (ctrl1_q[`TP_CR1_OCIE] & (flags_q[`TP_SR_COMPARE_FLAG_FIRST] | flags_q[`TP_SR_COMPARE_FLAG_SECOND])) |
                      (ctrl1_q[`TP_CR1_TOIE] & flags_q[`TP_SR_TOF]));
  assign wait_wake = timer_irq & wait_mode;

  always_ff @(posedge mclk)
  begin
    if (reset)
      rdata_q <= 8'h00;
    else if (rd_at)
    begin
      unique case (reg_addr)
        `TP_CTRL1:     rdata_q <= ctrl1_q;
        `TP_CTRL2:     rdata_q <= ctrl2_q;
        `TP_STATUS:    rdata_q <= flags_q;
        `TP_CAP1_HIGH: rdata_q <= cap1_q[15:8];
        `TP_CAP1_LOW:  rdata_q <= cap1_q[7:0];
        `TP_CAP2_HIGH: rdata_q <= cap2_q[15:8];
        `TP_CAP2_LOW:  rdata_q <= cap2_q[7:0];
        `TP_CMP1_HIGH: rdata_q <= cmp1_q[15:8];
        `TP_CMP1_LOW:  rdata_q <= cmp1_q[7:0];
        `TP_CMP2_HIGH: rdata_q <= cmp2_q[15:8];
        `TP_CMP2_LOW:  rdata_q <= cmp2_q[7:0];
        `TP_CNT_HIGH:  rdata_q <= cnt_q[15:8];
        `TP_CNT_LOW:   rdata_q <= cnt_q[7:0];
        default:       rdata_q <= 8'h00;
      endcase
    end
    else
      rdata_q <= 8'h00;
  end

  assign reg_rdata = rdata_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  chk_trigger_reload: assert property (trig |=> cnt_q == 16'hfffc && cap1_q == 16'hfffd && flags_q[7]
                                        && out1_q == $past(ctrl1_q[2]))
    else $error("one-pulse trigger did not reload and capture");
  chk_opm_no_cmp1: assert property (mode == MODE_ONE_PULSE && !flags_q[6] |=> !flags_q[6])
    else $error("first compare flag set in one-pulse");
  chk_pwm_period: assert property (pwm_wrap |=> cnt_q == 16'hfffc && flags_q[7]
                                    && out1_q == $past(ctrl1_q[2]))
    else $error("pwm second match did not restart the period");
  chk_pwm_no_cmp: assert property (mode == MODE_PWM |=> !$rose(flags_q[6]) && !$rose(flags_q[3]))
    else $error("compare flag set in pwm");
  chk_halt_freeze: assert property (halt_mode && $past(halt_mode) |-> cnt_q == $past(cnt_q))
    else $error("counter moved during halt");
  chk_flag_clear: assert property ($fell(flags_q[7]) |-> $past(clr_acc[7] && seen_q[7]))
    else $error("capture flag cleared without the two-step access");
  chk_cmp_suspend: assert property (mode == MODE_NORMAL && cmp_inh_q[0] && !flags_q[6] |=> !flags_q[6])
    else $error("compare matched while half written");
  chk_irq_capture: assert property (flags_q[7] && ctrl1_q[7] && !cpu_int_mask |-> timer_irq)
    else $error("capture flag did not request an interrupt");
  chk_tick_div4: assert property ((tick && tick_sel == 2'b00) ##1 (tick_sel == 2'b00 && !halt_mode)[*4]
                                   |-> tick && !$past(tick, 1) && !$past(tick, 2) && !$past(tick, 3))
    else $error("divide-by-four tick spacing wrong");

  cov_one_pulse: cover property (trig ##[1:1000] (mode == MODE_ONE_PULSE && match1));
  cov_pwm_wrap: cover property (pwm_wrap ##[1:1000] pwm_wrap);
  cov_halt_capture: cover property (halt_exit && cap_arm_q[1]);

endmodule

// ### verif/pin_partner.sv
// pin-side partner: trigger and capture sources, external tick source, load that times the waveform
// assumes one-cycle fire commands from the bench on mclk
`timescale 1ns/10ps

module pin_partner
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        fire_first,
  input  wire logic        fire_second,
  input  wire logic        ext_run,
  input  wire logic        wave_in,
  output logic             capture_input_first,
  output logic             capture_input_second,
  output logic             ext_tick_pin,
  output logic [15:0]      high_len,
  output logic [15:0]      period_len,
  output logic [7:0]       rise_count
);
  logic        wave_q;
  logic [15:0] since_q;
  logic        ext_half_q;

  // a fire command flips the pin, so the bench picks the edge sense from the level it left
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      capture_input_first  <= 1'b1;
      capture_input_second <= 1'b1;
    end
    else
    begin
      capture_input_first  <= capture_input_first ^ fire_first;
      capture_input_second <= capture_input_second ^ fire_second;
    end
  end

  // the external tick stands still unless run; one falling edge every 4 cycles while running
  always_ff @(posedge mclk)
  begin
    if (reset || !ext_run)
      ext_half_q <= 1'b0;
    else
      ext_half_q <= ~ext_half_q;
    if (reset)
      ext_tick_pin <= 1'b1;
    else if (ext_run && ext_half_q)
      ext_tick_pin <= ~ext_tick_pin;
  end

  // lengths in mclk cycles between rising edges and from rise to fall
  always_ff @(posedge mclk)
  begin
    wave_q <= wave_in;
    if (reset)
    begin
      since_q    <= 16'h0000;
      high_len   <= 16'h0000;
      period_len <= 16'h0000;
      rise_count <= 8'h00;
    end
    else if (wave_in && !wave_q)
    begin
      period_len <= since_q;
      since_q    <= 16'h0001;
      rise_count <= rise_count + 8'h01;
    end
    else
    begin
      since_q <= since_q + 16'h0001;
      if (!wave_in && wave_q)
        high_len <= since_q;
    end
  end
endmodule

// ### verif/timer_one_pulse_and_pwm_bench.sv
// self-checking bench of the one-pulse / pwm timer with its pin partner
// assumes the register map and bit layout of the constants header
`timescale 1ns/10ps
`include "timer_pulse_defines.svh"

module timer_one_pulse_and_pwm_bench;
  logic        mclk, reset, reg_wr, reg_rd, halt_mode, wait_mode, cpu_int_mask;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic        capture_input_first, capture_input_second, ext_tick_pin;
  logic        compare_output_first, compare_drive_first_n, timer_irq, wait_wake;
  logic        fire_first, fire_second, ext_run;
  logic [15:0] high_len, period_len;
  logic [7:0]  rise_count;
  int          fail_count, checked;

  timer_one_pulse_and_pwm i_timer_one_pulse_and_pwm (.mclk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .capture_input_first, .capture_input_second, .ext_tick_pin, .halt_mode, .wait_mode,
    .cpu_int_mask, .compare_output_first, .compare_drive_first_n, .compare_output_second(),
    .compare_drive_second_n(), .timer_irq, .wait_wake);

  pin_partner i_pin_partner (.mclk, .reset, .fire_first, .fire_second, .ext_run,
    .wave_in(compare_output_first), .capture_input_first, .capture_input_second, .ext_tick_pin,
    .high_len, .period_len, .rise_count);

  always #25 mclk = ~mclk;

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so they are taken just past that edge
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic fire(input logic second);
    @(posedge mclk);
    fire_first <= ~second;
    fire_second <= second;
    @(posedge mclk);
    fire_first <= 1'b0;
    fire_second <= 1'b0;
  endtask

  task automatic wait_level(input logic lvl, input int limit);
    int n;
    n = 0;
    while (compare_output_first !== lvl && n < limit)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("out_level", {15'h0000, lvl}, {15'h0000, compare_output_first});
  endtask

  task automatic hold_level(input logic lvl, input int n);
    logic bad;
    bad = 1'b0;
    repeat (n)
    begin
      @(posedge mclk);
      #1;
      if (compare_output_first !== lvl)
        bad = 1'b1;
    end
    chk("out_hold", 16'h0000, {15'h0000, bad});
  endtask

  task automatic wait_rises(input int k);
    int n;
    logic [7:0] start;
    n = 0;
    start = rise_count;
    while (rise_count - start < k[7:0] && n < 2000)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("rise_wait", 16'h0000, {15'h0000, n >= 2000});
  endtask

  task automatic test_reset_values;
    logic [3:0] addrs[5] = '{`TP_CTRL1, `TP_CTRL2, `TP_CMP1_HIGH, `TP_CMP2_HIGH, 4'hd};
    logic [7:0] exps[5] = '{8'h00, 8'h00, 8'h80, 8'h80, 8'h00};
    logic [7:0] d;
    for (int i = 0; i < 5; i++)
    begin
      rd(addrs[i], d);
      chk("reset_reg", {8'h00, exps[i]}, {8'h00, d});
    end
    chk("reset_irq", 16'h0000, {15'h0000, timer_irq});
  endtask

  task automatic test_one_pulse;
    logic [7:0] d;
    wr(`TP_CMP1_HIGH, 8'h00);
    wr(`TP_CMP1_LOW, 8'h10);
    wr(`TP_CTRL1, 8'h86);
    wr(`TP_CTRL2, 8'ha4);
    rd(`TP_STATUS, d);
    rd(`TP_CMP1_LOW, d);
    chk("drive_n", 16'h0000, {15'h0000, compare_drive_first_n});
    fire(1'b0);
    repeat (20) @(posedge mclk);
    #1;
    chk("falling_ignored", 16'h0000, {15'h0000, compare_output_first});
    fire(1'b0);
    wait_level(1'b1, 10);
    chk("trigger_irq", 16'h0001, {15'h0000, timer_irq});
    rd(`TP_CAP1_HIGH, d);
    chk("cap1_high", 16'h00ff, {8'h00, d});
    rd(`TP_CAP1_LOW, d);
    chk("cap1_low", 16'h00fd, {8'h00, d});
    fire(1'b1);
    wait_level(1'b0, 80);
    @(posedge mclk);
    #1;
    chk("pulse_len", 16'h0001, {15'h0000, high_len >= 41 && high_len <= 42});
    rd(`TP_STATUS, d);
    chk("one_pulse_flags", 16'h0090, {8'h00, d & 8'hd0});
    @(posedge mclk);
    wait_mode <= 1'b1;
    @(posedge mclk);
    #1;
    chk("wait_wake", 16'h0001, {15'h0000, wait_wake});
    rd(`TP_CAP1_LOW, d);
    rd(`TP_CAP2_LOW, d);
    chk("flags_cleared_irq", 16'h0000, {15'h0000, timer_irq});
    rd(`TP_STATUS, d);
    chk("flags_cleared", 16'h0000, {8'h00, d & 8'h90});
    @(posedge mclk);
    wait_mode <= 1'b0;
    hold_level(1'b0, 120);
  endtask

  task automatic test_pwm;
    int div[4] = '{4, 2, 8, 4};
    logic [7:0] d;
    wr(`TP_CMP1_HIGH, 8'h00);
    wr(`TP_CMP1_LOW, 8'h08);
    wr(`TP_CMP2_HIGH, 8'h00);
    wr(`TP_CMP2_LOW, 8'h20);
    wr(`TP_CTRL1, 8'h81);
    // a falling trigger restarts the counter, else it sits past both compares for a whole wrap
    fire(1'b0);
    repeat (4) @(posedge mclk);
    for (int i = 0; i < 4; i++)
    begin
      ext_run <= (i == 3);
      wr(`TP_CTRL2, {4'hb, i[1:0], 2'b00});
      wait_rises(1);
      fire(1'b0);
      wait_rises(2);
      chk("pwm_period", 16'(37 * div[i]), period_len);
      chk("pwm_high", 16'(24 * div[i]), high_len);
    end
    rd(`TP_STATUS, d);
    chk("pwm_flags", 16'h0080, {8'h00, d & 8'hc8});
    @(posedge mclk);
    cpu_int_mask <= 1'b1;
    @(posedge mclk);
    #1;
    chk("masked_irq", 16'h0000, {15'h0000, timer_irq});
    @(posedge mclk);
    cpu_int_mask <= 1'b0;
    ext_run <= 1'b0;
    wr(`TP_CTRL2, 8'hb4);
    wr(`TP_CMP2_HIGH, 8'h00);
    wait_level(1'b1, 100);
    hold_level(1'b1, 300);
    wr(`TP_CMP2_LOW, 8'hf0);
    wait_level(1'b0, 250);
    wr(`TP_CTRL1, 8'h85);
    wait_level(1'b1, 600);
    hold_level(1'b1, 600);
  endtask

  task automatic test_halt;
    logic [7:0] a, b;
    @(posedge mclk);
    halt_mode <= 1'b1;
    rd(`TP_CNT_LOW, a);
    fire(1'b1);
    fire(1'b1);
    repeat (20) @(posedge mclk);
    rd(`TP_CNT_LOW, b);
    chk("halt_count", {8'h00, a}, {8'h00, b});
    @(posedge mclk);
    halt_mode <= 1'b0;
    rd(`TP_STATUS, b);
    chk("halt_capture_flag", 16'h0010, {8'h00, b & 8'h10});
    rd(`TP_CAP2_HIGH, b);
    rd(`TP_CAP2_LOW, b);
    chk("halt_capture", {8'h00, a}, {8'h00, b});
    rd(`TP_CNT_LOW, b);
    chk("count_resumed", 16'h0001, {15'h0000, b !== a});
  endtask

  task automatic print_verdict;
    if (fail_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (30000) @(posedge mclk);
    fail_count++;
    print_verdict();
  end

  initial
  begin
    mclk = 1'b0;
    reset <= 1'b1;
    {reg_wr, reg_rd, halt_mode, wait_mode, cpu_int_mask} <= 5'h00;
    {fire_first, fire_second, ext_run} <= 3'h0;
    reg_addr <= 4'h0;
    reg_wdata <= 8'h00;
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    repeat (3) @(posedge mclk);
    test_reset_values();
    test_one_pulse();
    test_pwm();
    test_halt();
    print_verdict();
  end
endmodule
